// [cis_map.vh]
// cis_map.vh - encodings, address map and reset values for the core subset
// assumed: included by bare name from every design file that needs it
`ifndef CIS_MAP_VH
`define CIS_MAP_VH

// phases of one instruction cycle, one clk each
`define CIS_Q1 2'd0
`define CIS_Q2 2'd1
`define CIS_Q3 2'd2
`define CIS_Q4 2'd3

// opcode matches on the first word; CIS_IMOVE2_OP, for the move's second word, is never matched by the core
`define CIS_ROT_OP     6'h10
`define CIS_SET_OP     7'h34
`define CIS_WCALL_OP   16'h0014
`define CIS_IMOVE_OP   9'h1d6
`define CIS_IMOVE2_OP  4'hf

// access bank split and data space
`define CIS_ACC_SPLIT  8'h60
`define CIS_ACC_HIGH   4'hf
`define CIS_DATA_AW    12
`define CIS_PC_STEP    21'h000002

// indirect-addressing register windows (first..last)
`define CIS_IND0_LO    12'hfeb
`define CIS_IND0_HI    12'hfef
`define CIS_IND1_LO    12'hfe3
`define CIS_IND1_HI    12'hfe7
`define CIS_IND2_LO    12'hfdb
`define CIS_IND2_HI    12'hfdf

// return stack
`define CIS_STK_AW     5
`define CIS_STK_DEPTH  5'd31

// reset values
`define CIS_RST_BYTE   8'h00
`define CIS_RST_PC     21'h000000
`define CIS_RST_WORD   16'h0000
`define CIS_RST_ADDR   12'h000
`define CIS_RST_DEPTH  5'd0
`define CIS_ALL_ONES   8'hff

// side load selectors
`define CIS_LD_WORK    3'd0
`define CIS_LD_PCHI    3'd1
`define CIS_LD_PCUP    3'd2
`define CIS_LD_PTRLO   3'd3
`define CIS_LD_PTRHI   3'd4
`define CIS_LD_BSR     3'd5

`endif

// [cis_ram.v]
// cis_ram.v - simple dual-port memory, one write port, one registered read
// assumed: single clock, read returns the old word on a same-address write
`timescale 1ns/1ns
module cis_ram #(
  parameter AW = 12,
  parameter DW = 8
) (
  // clock
  input  wire          clk,
  // write port
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  // read port
  input  wire [AW-1:0] raddr,
  output reg  [DW-1:0] rdata
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// [cis_core.v]
// cis_core.v - execution of rotate, set, call-via-W and indexed move
// assumed: four clk per instruction cycle; instruction words are offered
// by same-clock fetch logic on a valid/ready pair at phase Q1.
//
// Contract
// RQ1 - rotate right moves bit0 into bit7, carry untouched
// RQ2 - destination bit 0 writes working register, 1 writes the file register
// RQ3 - rotate updates only N and Z; one word, one cycle
// RQ4 - set instruction writes all ones, flags untouched
// RQ5 - call via W pushes program counter plus two onto the stack
// RQ6 - call via W loads working register into pc low byte
// RQ7 - call via W loads pc high and upper bytes from latches
// RQ8 - call via W takes two cycles, second is a no-operation
// RQ9 - call via W leaves W, status and bank select unchanged
// RQ10 - indexed source is third pointer plus unsigned 7-bit offset
// RQ11 - indexed destination is the 12-bit field of word two
// RQ12 - source and destination reach the whole 4096-byte data space
// RQ13 - software never targets pc low or stack top bytes with the move
// RQ14 - a source in an indirect register window moves zero
`timescale 1ns/1ns
`include "cis_map.vh"
module cis_core (
  // clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // instruction words
  input  wire        ins_valid,
  input  wire [15:0] ins_word,
  output wire        ins_ready,
  output reg         ins_other,
  // side load of core registers, honoured at Q1 while idle and no word is taken
  input  wire        ld_we,
  input  wire [2:0]  ld_sel,
  input  wire [7:0]  ld_data,
  // data memory debug access, honoured while idle
  input  wire        dbg_en,
  input  wire        dbg_we,
  input  wire [11:0] dbg_addr,
  input  wire [7:0]  dbg_wdata,
  output wire [7:0]  dbg_rdata,
  // visible core state
  output reg  [7:0]  working_register,
  output reg         flag_negative,
  output reg         flag_zero,
  output reg  [20:0] pc,
  output reg  [7:0]  pc_high_latch,
  output reg  [7:0]  pc_upper_latch,
  output reg  [11:0] third_file_select_pointer,
  output reg  [7:0]  bank_select_reg,
  output wire [20:0] stack_top,
  output reg  [4:0]  stack_depth,
  output reg  [1:0]  phase
);

  // one instruction cycle is Q1..Q4: a word is taken on the Q1 edge and a
  // one-cycle instruction retires on the Q4 edge, so the next Q1 is free
  localparam ST_IDLE  = 3'd0;
  localparam ST_EXEC  = 3'd1;
  localparam ST_CALL1 = 3'd2;
  localparam ST_CALL2 = 3'd3;
  localparam ST_MOV1  = 3'd4;
  localparam ST_MOV2  = 3'd5;

  reg  [2:0]  state;
  reg  [15:0] ir;
  reg  [7:0]  result;
  reg  [7:0]  move_data;
  reg  [11:0] move_dest;
  reg         have_word2;

  wire [7:0]  mem_rdata;
  reg         mem_we;
  reg  [11:0] mem_waddr;
  reg  [7:0]  mem_wdata;
  reg  [11:0] mem_raddr;

  wire        stk_we;
  wire [4:0]  stk_raddr;

  // banked or access-bank address of an 8-bit file operand
  function [11:0] file_addr;
    input [7:0] f;
    input       a;
    input [7:0] bank;
    begin
      if (a) begin
        file_addr = {bank[3:0], f};
      end else if (f < `CIS_ACC_SPLIT) begin
        file_addr = {4'h0, f};
      end else begin
        file_addr = {`CIS_ACC_HIGH, f};
      end
    end
  endfunction

  // true for any of the three indirect-addressing windows
  function is_indirect;
    input [11:0] ad;
    begin
      is_indirect = (ad >= `CIS_IND0_LO && ad <= `CIS_IND0_HI) ||
                    (ad >= `CIS_IND1_LO && ad <= `CIS_IND1_HI) ||
                    (ad >= `CIS_IND2_LO && ad <= `CIS_IND2_HI);
    end
  endfunction

  wire is_rot   = (ins_word[15:10] == `CIS_ROT_OP);
  wire is_set   = (ins_word[15:9] == `CIS_SET_OP);
  wire is_wcall = (ins_word == `CIS_WCALL_OP);
  wire is_imove = (ins_word[15:7] == `CIS_IMOVE_OP);

  wire ir_set   = (ir[15:9] == `CIS_SET_OP);
  wire [11:0] ir_faddr = file_addr(ir[7:0], ir[8], bank_select_reg);
  // offset is zero-extended, the sum wraps inside the data space
  wire [11:0] src_addr = third_file_select_pointer + {5'h00, ir[6:0]}; // RQ10 RQ12
  wire        idle_free = (state == ST_IDLE) && !dbg_en;
  // call target; upper latch bits above pc[20] have nowhere to go
  wire [20:0] call_target = {pc_upper_latch[4:0], pc_high_latch, working_register}; // RQ6 RQ7

  // second word of the move is the only other word accepted mid-instruction
  assign ins_ready = !sys_rst && (phase == `CIS_Q1) &&
                     (idle_free || (state == ST_MOV2 && !have_word2));
  wire take = ins_valid && ins_ready;

  // memory port steering
  always @* begin
    mem_we    = 1'b0;
    mem_waddr = dbg_addr;
    mem_wdata = dbg_wdata;
    mem_raddr = dbg_addr;
    if (state == ST_EXEC) begin
      mem_raddr = ir_faddr;
      mem_waddr = ir_faddr;
      mem_wdata = result;
      mem_we    = (phase == `CIS_Q4) && (ir_set || ir[9]); // RQ2 RQ4
    end else if (state == ST_MOV1) begin
      mem_raddr = src_addr; // RQ10
    end else if (state == ST_MOV2) begin
      // pc low and stack top bytes are not special here; code avoids them
      mem_waddr = move_dest; // RQ11 RQ13
      mem_wdata = move_data;
      mem_we    = (phase == `CIS_Q4) && have_word2;
    // the debug port owns the memory only while no instruction runs
    end else if (state == ST_IDLE && dbg_en) begin
      mem_we = dbg_we;
    end
  end

  assign dbg_rdata = mem_rdata;

  cis_ram #(
    .AW (`CIS_DATA_AW),
    .DW (8)
  ) u_data (
    .clk   (clk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  // a full stack drops the push rather than overwrite the oldest entry
  assign stk_we    = (state == ST_CALL1) && (phase == `CIS_Q3) &&
                     (stack_depth != `CIS_STK_DEPTH);
  assign stk_raddr = stack_depth - 5'd1;

  // stack read runs one clk behind the depth, so stack_top lags a push
  cis_ram #(
    .AW (`CIS_STK_AW),
    .DW (21)
  ) u_stack (
    .clk   (clk),
    .we    (stk_we),
    .waddr (stack_depth),
    .wdata (pc),
    .raddr (stk_raddr),
    .rdata (stack_top)
  );

  always @(posedge clk) begin
    if (sys_rst) begin
      phase                     <= `CIS_Q1;
      state                     <= ST_IDLE;
      ir                        <= `CIS_RST_WORD;
      result                    <= `CIS_RST_BYTE;
      move_data                 <= `CIS_RST_BYTE;
      move_dest                 <= `CIS_RST_ADDR;
      have_word2                <= 1'b0;
      ins_other                 <= 1'b0;
      working_register          <= `CIS_RST_BYTE;
      flag_negative             <= 1'b0;
      flag_zero                 <= 1'b0;
      pc                        <= `CIS_RST_PC;
      pc_high_latch             <= `CIS_RST_BYTE;
      pc_upper_latch            <= `CIS_RST_BYTE;
      third_file_select_pointer <= `CIS_RST_ADDR;
      bank_select_reg           <= `CIS_RST_BYTE;
      stack_depth               <= `CIS_RST_DEPTH;
    end else begin
      // the phase counter free-runs and wraps from Q4 back to Q1
      phase     <= phase + 2'd1;
      ins_other <= 1'b0;
      if (take) begin
        pc <= pc + `CIS_PC_STEP;
      end
      case (state)
        ST_IDLE: begin
          if (take) begin
            ir <= ins_word;
            if (is_rot || is_set) begin
              state <= ST_EXEC;
            end else if (is_wcall) begin
              state <= ST_CALL1;
            end else if (is_imove) begin
              state <= ST_MOV1;
            end else begin
              // anything else runs as a one-cycle no-operation
              ins_other <= 1'b1;
            end
          end else if (ld_we && phase == `CIS_Q1) begin
            if (ld_sel == `CIS_LD_WORK) begin
              working_register <= ld_data;
            end else if (ld_sel == `CIS_LD_PCHI) begin
              pc_high_latch <= ld_data;
            end else if (ld_sel == `CIS_LD_PCUP) begin
              pc_upper_latch <= ld_data;
            end else if (ld_sel == `CIS_LD_PTRLO) begin
              third_file_select_pointer[7:0] <= ld_data;
            end else if (ld_sel == `CIS_LD_PTRHI) begin
              // only four bits exist above the low byte of a 12-bit address
              third_file_select_pointer[11:8] <= ld_data[3:0];
            end else if (ld_sel == `CIS_LD_BSR) begin
              bank_select_reg <= ld_data;
            end
          end
        end
        ST_EXEC: begin
          // data memory read is registered: the Q2 address returns data in Q3
          if (phase == `CIS_Q3) begin
            if (ir_set) begin
              result <= `CIS_ALL_ONES; // RQ4
            end else begin
              result <= {mem_rdata[0], mem_rdata[7:1]}; // RQ1
            end
          end
          if (phase == `CIS_Q4) begin
            if (!ir_set) begin
              flag_negative <= result[7]; // RQ3
              flag_zero     <= (result == 8'h00); // RQ3
              if (!ir[9]) begin
                working_register <= result; // RQ2
              end
            end
            state <= ST_IDLE; // RQ3
          end
        end
        ST_CALL1: begin
          // pc already stepped past this word, so it is the return address
          if (stk_we) begin
            stack_depth <= stack_depth + 5'd1; // RQ5
          end
          if (phase == `CIS_Q4) begin
            pc    <= call_target; // RQ6 RQ7 RQ9
            state <= ST_CALL2;
          end
        end
        ST_CALL2: begin
          // no operation while the word at the target is fetched
          if (phase == `CIS_Q4) begin
            state <= ST_IDLE; // RQ8
          end
        end
        ST_MOV1: begin
          // the source is read every phase; the Q4 sample is the one kept
          if (phase == `CIS_Q4) begin
            if (is_indirect(src_addr)) begin
              move_data <= 8'h00; // RQ14
            end else begin
              move_data <= mem_rdata;
            end
            state <= ST_MOV2;
          end
        end
        ST_MOV2: begin
          // a late second word just holds the move over the following Q1 slots
          if (take) begin
            move_dest  <= ins_word[11:0]; // RQ11 RQ12
            have_word2 <= 1'b1;
          end
          if (phase == `CIS_Q4 && have_word2) begin
            have_word2 <= 1'b0;
            state      <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// [cis_core_props.sv]
// cis_core_props.sv - timing and state checks for the core subset
// assumed: watches the cis_core ports only; one clock, sync reset high
`timescale 1ns/1ns
`include "cis_map.vh"
module cis_core_props (
  // clock and reset
  input logic        clk,
  input logic        sys_rst,
  // instruction port
  input logic        ins_valid,
  input logic [15:0] ins_word,
  input logic        ins_ready,
  // visible state
  input logic [7:0]  working_register,
  input logic        flag_negative,
  input logic        flag_zero,
  input logic [20:0] pc,
  input logic [7:0]  pc_high_latch,
  input logic [7:0]  pc_upper_latch,
  input logic [7:0]  bank_select_reg,
  input logic [20:0] stack_top,
  input logic [4:0]  stack_depth
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  wire take = ins_valid && ins_ready;
  wire rot  = take && ins_word[15:10] == `CIS_ROT_OP;
  wire set_take = take && ins_word[15:9] == `CIS_SET_OP;

  sequence wcall_take;
    take && ins_word == `CIS_WCALL_OP;
  endsequence

  pc_step_a: assert property (take |=> pc == $past(pc) + `CIS_PC_STEP)
    else $error("pc did not step by two on a take");
  wcall_nop_a: assert property (wcall_take |=> !ins_ready [*7])
    else $error("word accepted inside the call cycles");
  wcall_pc_a: assert property (wcall_take |-> ##5
    pc == {pc_upper_latch[4:0], pc_high_latch, working_register})
    else $error("call target wrong");
  wcall_push_a: assert property (wcall_take ##0 stack_depth != `CIS_STK_DEPTH
    |-> ##5 stack_depth == $past(stack_depth, 5) + 5'd1)
    else $error("call did not push");
  wcall_ret_a: assert property (wcall_take |-> ##6 stack_top == $past(pc, 5))
    else $error("pushed address wrong");
  wcall_keep_a: assert property (wcall_take |=> ($stable(working_register)
    && $stable(bank_select_reg) && $stable(flag_zero) && $stable(flag_negative)) [*7])
    else $error("call changed core state");
  set_flags_a: assert property (set_take |=>
    ($stable(flag_zero) && $stable(flag_negative)) [*5])
    else $error("set changed flags");
  rot_flags_a: assert property (rot && !ins_word[9] |-> ##5
    flag_zero == (working_register == 8'h00) && flag_negative == working_register[7])
    else $error("rotate flags wrong");
  rot_keep_a: assert property (rot && ins_word[9] |=> $stable(working_register) [*5])
    else $error("rotate to file changed W");
endmodule

bind cis_core cis_core_props u_cis_core_props (.clk(clk), .sys_rst(sys_rst),
  .ins_valid(ins_valid), .ins_word(ins_word), .ins_ready(ins_ready),
  .working_register(working_register), .flag_negative(flag_negative),
  .flag_zero(flag_zero), .pc(pc), .pc_high_latch(pc_high_latch),
  .pc_upper_latch(pc_upper_latch), .bank_select_reg(bank_select_reg),
  .stack_top(stack_top), .stack_depth(stack_depth));

// [tb_top.sv]
// tb_top.sv - directed bench for rotate, set, call via W and indexed move
// assumed: inputs change on falling clk edges; memory reached via debug port
`timescale 1ns/1ns
`include "cis_map.vh"
module tb_top;
  reg         clk = 1'b0;
  reg         sys_rst, ins_valid, ld_we, dbg_en, dbg_we;
  reg  [15:0] ins_word;
  reg  [2:0]  ld_sel;
  reg  [7:0]  ld_data, dbg_wdata, d;
  reg  [11:0] dbg_addr;
  wire        ins_ready, ins_other, flag_negative, flag_zero;
  wire [7:0]  dbg_rdata, working_register, pc_high_latch, pc_upper_latch, bank_select_reg;
  wire [20:0] pc, stack_top;
  wire [11:0] third_file_select_pointer;
  wire [4:0]  stack_depth;
  wire [1:0]  phase;
  reg  [20:0] p;
  reg  [4:0]  dep;
  integer     n_mismatch = 0;
  integer     cmp_count = 0;

  cis_core u_cis_core (.clk(clk), .sys_rst(sys_rst), .ins_valid(ins_valid),
    .ins_word(ins_word), .ins_ready(ins_ready), .ins_other(ins_other), .ld_we(ld_we),
    .ld_sel(ld_sel), .ld_data(ld_data), .dbg_en(dbg_en), .dbg_we(dbg_we),
    .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata), .dbg_rdata(dbg_rdata),
    .working_register(working_register), .flag_negative(flag_negative),
    .flag_zero(flag_zero), .pc(pc), .pc_high_latch(pc_high_latch),
    .pc_upper_latch(pc_upper_latch), .third_file_select_pointer(third_file_select_pointer),
    .bank_select_reg(bank_select_reg), .stack_top(stack_top),
    .stack_depth(stack_depth), .phase(phase));

  always #25 clk = ~clk;

  task close_out;
    begin
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task wt(input integer n);
    repeat (n) @(negedge clk);
  endtask

  // waits for a phase-0 slot the core will accept
  task issue(input [15:0] w);
    begin
      while (!(phase === 2'd0 && ins_ready === 1'b1))
        @(negedge clk);
      ins_word = w;
      ins_valid = 1'b1;
      @(negedge clk);
      ins_valid = 1'b0;
    end
  endtask

  task ld(input [2:0] s, input [7:0] v);
    begin
      while (phase !== 2'd0)
        @(negedge clk);
      ld_sel = s;
      ld_data = v;
      ld_we = 1'b1;
      @(negedge clk);
      ld_we = 1'b0;
    end
  endtask

  task mw(input [11:0] a, input [7:0] v);
    begin
      dbg_en = 1'b1;
      dbg_we = 1'b1;
      dbg_addr = a;
      dbg_wdata = v;
      @(negedge clk);
      dbg_we = 1'b0;
      dbg_en = 1'b0;
      // one idle clk so a following access never re-raises dbg_en at once
      @(negedge clk);
    end
  endtask

  task mr(input [11:0] a);
    begin
      dbg_en = 1'b1;
      dbg_addr = a;
      wt(2);
      d = dbg_rdata;
      dbg_en = 1'b0;
      @(negedge clk);
    end
  endtask

  task t_rot;
    begin
      // access bank, low part: a=0, f=0x30 lands on 0x030
      mw(12'h030, 8'h01);
      issue(16'h4230);
      wt(8);
      mr(12'h030);
      chk(d, 8'h80);
      chk({flag_negative, flag_zero}, 2'b10);
      ld(3'd5, 8'h02);
      mw(12'h220, 8'hd7);
      issue(16'h4320);
      wt(8);
      mr(12'h220);
      chk(d, 8'heb);
      chk({flag_negative, flag_zero}, 2'b10);
      issue(16'h4120);
      wt(8);
      chk(working_register, 8'hf5);
      mr(12'h220);
      chk(d, 8'heb);
      mw(12'h222, 8'h00);
      issue(16'h4122);
      wt(8);
      chk({flag_negative, flag_zero}, 2'b01);
    end
  endtask

  task t_set;
    begin
      mw(12'h221, 8'h5a);
      issue(16'h6921);
      wt(8);
      mr(12'h221);
      chk(d, `CIS_ALL_ONES);
      chk({flag_negative, flag_zero}, 2'b01);
      // access bank, high part: a=0, f=0x80 lands on 0xf80
      mw(12'hf80, 8'h11);
      issue(16'h6880);
      wt(8);
      mr(12'hf80);
      chk(d, `CIS_ALL_ONES);
      chk({flag_negative, flag_zero}, 2'b01);
    end
  endtask

  // a word outside the subset runs as a one-cycle no-operation
  task t_other;
    begin
      p = pc;
      issue(16'h0000);
      chk(ins_other, 1'b1);
      chk(phase, 2'd1);
      chk(pc, p + 21'd2);
      wt(1);
      chk(ins_other, 1'b0);
      wt(2);
      chk(ins_ready, 1'b1);
    end
  endtask

  task t_call;
    begin
      ld(3'd0, 8'h06);
      ld(3'd1, 8'h10);
      ld(3'd2, 8'h03);
      p = pc;
      dep = stack_depth;
      issue(`CIS_WCALL_OP);
      wt(3);
      chk(ins_ready, 1'b0);
      wt(4);
      chk(ins_ready, 1'b1);
      chk(pc, {5'h03, 8'h10, 8'h06});
      chk(stack_top, p + 21'd2);
      chk(stack_depth, dep + 5'd1);
      chk({working_register, bank_select_reg}, 16'h0602);
      chk({flag_negative, flag_zero}, 2'b01);
      chk({pc_high_latch, pc_upper_latch}, 16'h1003);
    end
  endtask

  // destinations stay clear of pc low and stack top bytes
  task t_move(input [11:0] ptr, input [6:0] off, input [11:0] dst, input [7:0] sv,
              input [7:0] exp);
    begin
      ld(3'd3, ptr[7:0]);
      ld(3'd4, {4'h0, ptr[11:8]});
      mw(ptr + {5'h00, off}, sv);
      mw(dst, ~exp);
      issue({`CIS_IMOVE_OP, off});
      issue({4'hf, dst});
      wt(10);
      mr(dst);
      chk(d, exp);
      chk(third_file_select_pointer, ptr);
    end
  endtask

  initial begin
    {sys_rst, ins_valid, ld_we, dbg_en, dbg_we} = 5'h10;
    {ins_word, ld_sel, ld_data, dbg_addr, dbg_wdata} = 47'h0;
    wt(5);
    sys_rst = 1'b0;
    wt(1);
    t_rot;
    t_set;
    t_other;
    t_call;
    t_move(12'h180, 7'h05, 12'h2ff, 8'h33, 8'h33);
    t_move(12'hf80, 7'h7f, 12'h000, 8'hc4, 8'hc4);
    t_move(12'hfe0, 7'h0b, 12'h100, 8'h77, 8'h00);
    t_move(12'hfd0, 7'h0b, 12'h101, 8'h55, 8'h00);
    t_move(12'hfe0, 7'h07, 12'h102, 8'h66, 8'h00);
    close_out;
  end

  // the whole run needs well under 1000 cycles
  initial begin
    #200000;
    n_mismatch = n_mismatch + 1;
    close_out;
  end
endmodule
